// *** hw/paic_pkg.sv ***
// package: register map, field layout and timing for the polled adc card port
// Operation
// - card decodes sixteen ports from its base
// - offset 4 reads result low byte
// - offset 5 reads high nibble plus flag
// - flag is one while converting, then zero
// - result is twelve bit straight binary
// - offset 9 write sets two bit gain
// - offset 10 write sets five bit channel
// - host selects channel, then waits 5 us
// - offset 12 write starts one conversion
// - host waits 20 us before polling
// - host polls flag until it reads zero
// - host reads high byte, then low byte
// - six switch bits match address a9..a4
// - conversion keeps busy about 25 us
package paic_pkg;
  localparam int CLK_MHZ = 50;
  localparam logic [3:0] OFS_RES_LO = 4'h4;
  localparam logic [3:0] OFS_RES_HI = 4'h5;
  localparam logic [3:0] OFS_GAIN = 4'h9;
  localparam logic [3:0] OFS_CHAN = 4'ha;
  localparam logic [3:0] OFS_TRIG = 4'hc;
  localparam int BUSY_BIT = 4;
  localparam int CONV_US = 25;
  localparam int SETTLE_US = 5;
  localparam int POLL_WAIT_US = 20;
  localparam int CONV_CYC = CONV_US * CLK_MHZ;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int POLL_CYC = POLL_WAIT_US * CLK_MHZ;
  // controller register offsets
  localparam logic [2:0] CR_CTRL = 3'h0;
  localparam logic [2:0] CR_CHAN = 3'h1;
  localparam logic [2:0] CR_GAIN = 3'h2;
  localparam logic [2:0] CR_RESULT = 3'h3;
  localparam logic [2:0] CR_STAT = 3'h4;
  localparam logic [2:0] CR_IRQ_ST = 3'h5;
  localparam logic [2:0] CR_IRQ_MASK = 3'h6;
  localparam logic [2:0] CR_BASE = 3'h7;
  localparam logic [5:0] BASE_RST = 6'h22;
  function automatic logic [10:0] cyc_to_cnt(input int n);
    return n[10:0];
  endfunction
endpackage

// *** hw/paic_if.sv ***
// interface: host i/o bus between controller and card
`timescale 1ns/1ps
interface paic_if;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic rvalid;
  modport card (input addr, input wdata, input wr, input rd, output rdata, output rvalid);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input rvalid);
endinterface

// *** hw/paic_card.sv ***
// card end: i/o window decode, gain/channel registers, conversion timer
`timescale 1ns/1ps
module paic_card
  import paic_pkg::*;
(
  input wire logic clk, // 50 mhz
  input wire logic rstn, // sync reset, low
  paic_if.card bus, // host i/o bus
  input wire logic [5:0] base_address_switch, // base a9..a4
  input wire logic [11:0] adc_sample, // converter output word
  output logic [1:0] gain_code, // amplifier gain
  output logic [4:0] channel_code, // input multiplexer select
  output logic conv_start // pulse to converter
);
  logic [1:0] gain_r;
  logic [4:0] chan_r;
  logic [11:0] result_r;
  logic [10:0] cnt_r;
  logic busy_r;
  logic start_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  // window hit and offset decode
  wire hit = bus.addr[9:4] == base_address_switch;
  wire [3:0] ofs = bus.addr[3:0];
  wire wr_gain = hit && bus.wr && ofs == OFS_GAIN;
  wire wr_chan = hit && bus.wr && ofs == OFS_CHAN;
  wire wr_trig = hit && bus.wr && ofs == OFS_TRIG && !busy_r;
  wire [7:0] hi_byte = {3'h0, busy_r, result_r[11:8]};
  wire [7:0] rd_mux = (ofs == OFS_RES_LO) ? result_r[7:0] :
                      (ofs == OFS_RES_HI) ? hi_byte : 8'h00;
  // control registers; other writes ignored
  always_ff @(posedge clk) begin
    if (!rstn) begin
      gain_r <= 2'h0;
      chan_r <= 5'h00;
    end else begin
      if (wr_gain) gain_r <= bus.wdata[1:0];
      if (wr_chan) chan_r <= bus.wdata[4:0];
    end
  end
  // conversion timer and result capture
  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy_r <= 1'b0;
      cnt_r <= 11'h000;
      start_r <= 1'b0;
      result_r <= 12'h000;
    end else begin
      start_r <= wr_trig;
      if (wr_trig) begin
        busy_r <= 1'b1;
        cnt_r <= cyc_to_cnt(CONV_CYC - 1);
      end else if (busy_r) begin
        if (cnt_r == 11'h000) begin
          busy_r <= 1'b0;
          result_r <= adc_sample;
        end else begin
          cnt_r <= cnt_r - 11'h001;
        end
      end
    end
  end
  // read answer one cycle later
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= hit && bus.rd;
      rdata_r <= (hit && bus.rd) ? rd_mux : 8'h00;
    end
  end
  assign bus.rdata = rdata_r;
  assign bus.rvalid = rvalid_r;
  assign gain_code = gain_r;
  assign channel_code = chan_r;
  assign conv_start = start_r;
endmodule // paic_card

// *** hw/paic_host.sv ***
// host end: register port drives select, trigger, poll and read sequence
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module paic_host
  import paic_pkg::*;
(
  input wire logic clk, // 50 mhz
  input wire logic rstn, // sync reset, low
  input wire logic [2:0] reg_addr, // register address
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata, // read data, next cycle
  output logic irq, // level interrupt
  paic_if.host bus // card i/o bus
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_WGAIN = 4'b0001, S_WCHAN = 4'b0010, S_SETTLE = 4'b0011,
    S_TRIG = 4'b0100, S_WAIT = 4'b0101, S_POLL = 4'b0110, S_PWAIT = 4'b0111,
    S_RDHI = 4'b1000, S_HWAIT = 4'b1001, S_RDLO = 4'b1010, S_LWAIT = 4'b1011
  } paic_state_t;
  paic_state_t st_r, st_nxt;
  logic [4:0] chan_r;
  logic [1:0] gain_r;
  logic [5:0] base_r;
  logic [11:0] res_r;
  logic [3:0] hi_r;
  logic [10:0] cnt_r;
  logic [1:0] ist_r, imask_r;
  logic [15:0] rdata_r;
  logic irq_r;
  logic [9:0] addr_r;
  logic [7:0] wdata_r;
  logic wr_r, rd_r;
  wire go = reg_wr && reg_addr == CR_CTRL && reg_wdata[0] && st_r == S_IDLE;
  wire cnt_zero = cnt_r == 11'h000;
  wire done_ev = st_r == S_LWAIT && bus.rvalid;
  wire poll_ev = st_r == S_PWAIT && bus.rvalid;
  wire [1:0] ev = {done_ev, go};
  // next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      S_IDLE: if (go) st_nxt = S_WGAIN;
      S_WGAIN: st_nxt = S_WCHAN;
      S_WCHAN: st_nxt = S_SETTLE;
      S_SETTLE: if (cnt_zero) st_nxt = S_TRIG;
      S_TRIG: st_nxt = S_WAIT;
      S_WAIT: if (cnt_zero) st_nxt = S_POLL;
      S_POLL: st_nxt = S_PWAIT;
      S_PWAIT: if (bus.rvalid) st_nxt = bus.rdata[BUSY_BIT] ? S_POLL : S_RDHI;
      S_RDHI: st_nxt = S_HWAIT;
      S_HWAIT: if (bus.rvalid) st_nxt = S_RDLO;
      S_RDLO: st_nxt = S_LWAIT;
      S_LWAIT: if (bus.rvalid) st_nxt = S_IDLE;
      default: st_nxt = S_IDLE;
    endcase
  end
  // bus cycle for this state
  wire [3:0] ofs_nxt = (st_nxt == S_WGAIN) ? OFS_GAIN : (st_nxt == S_WCHAN) ? OFS_CHAN :
                       (st_nxt == S_TRIG) ? OFS_TRIG :
                       (st_nxt == S_RDLO) ? OFS_RES_LO : OFS_RES_HI;
  wire wr_nxt = st_nxt == S_WGAIN || st_nxt == S_WCHAN || st_nxt == S_TRIG;
  wire rd_nxt = st_nxt == S_POLL || st_nxt == S_RDHI || st_nxt == S_RDLO;
  wire [7:0] wd_nxt = (st_nxt == S_WGAIN) ? {6'h00, gain_r} : {3'h0, chan_r};
  // sequencer and bus drive
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= S_IDLE;
      cnt_r <= 11'h000;
      addr_r <= 10'h000;
      wdata_r <= 8'h00;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      addr_r <= {base_r, ofs_nxt};
      wdata_r <= wd_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      if (st_nxt == S_SETTLE && st_r != S_SETTLE) cnt_r <= cyc_to_cnt(SETTLE_CYC - 1);
      else if (st_nxt == S_WAIT && st_r != S_WAIT) cnt_r <= cyc_to_cnt(POLL_CYC - 1);
      else if (!cnt_zero) cnt_r <= cnt_r - 11'h001;
    end
  end
  // captured result bytes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hi_r <= 4'h0;
      res_r <= 12'h000;
    end else begin
      if (st_r == S_HWAIT && bus.rvalid) hi_r <= bus.rdata[3:0];
      if (done_ev) res_r <= {hi_r, bus.rdata};
    end
  end
  // software registers and interrupt
  always_ff @(posedge clk) begin
    if (!rstn) begin
      chan_r <= 5'h00;
      gain_r <= 2'h0;
      base_r <= BASE_RST;
      imask_r <= 2'h0;
      ist_r <= 2'h0;
      rdata_r <= 16'h0000;
      irq_r <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == CR_CHAN) chan_r <= reg_wdata[4:0];
      if (reg_wr && reg_addr == CR_GAIN) gain_r <= reg_wdata[1:0];
      if (reg_wr && reg_addr == CR_BASE) base_r <= reg_wdata[5:0];
      if (reg_wr && reg_addr == CR_IRQ_MASK) imask_r <= reg_wdata[1:0];
      ist_r <= ev | (ist_r & ~((reg_wr && reg_addr == CR_IRQ_ST) ? reg_wdata[1:0] : 2'h0));
      irq_r <= |(ist_r & imask_r);
      if (reg_rd) begin
        unique case (reg_addr)
          CR_CHAN: rdata_r <= {11'h000, chan_r};
          CR_GAIN: rdata_r <= {14'h0000, gain_r};
          CR_RESULT: rdata_r <= {4'h0, res_r};
          CR_STAT: rdata_r <= {11'h000, poll_ev, st_r};
          CR_IRQ_ST: rdata_r <= {14'h0000, ist_r};
          CR_IRQ_MASK: rdata_r <= {14'h0000, imask_r};
          CR_BASE: rdata_r <= {10'h000, base_r};
          CR_CTRL: rdata_r <= {15'h0000, st_r != S_IDLE};
        endcase
      end else begin
        rdata_r <= 16'h0000;
      end
    end
  end
  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.wr = wr_r;
  assign bus.rd = rd_r;
  assign reg_rdata = rdata_r;
  assign irq = irq_r;
endmodule // paic_host

// *** test/paic_assertions.sv ***
// checker: card bus answers, busy flag and host order
`timescale 1ns/1ps
module paic_assertions
  import paic_pkg::*;
#(parameter logic [5:0] BASE = 6'h22)
(
  input wire logic clk, // clock
  input wire logic rstn, // reset, low
  input wire logic [9:0] addr, // address
  input wire logic [7:0] wdata, // data
  input wire logic wr, // write
  input wire logic rd, // read
  input wire logic [7:0] rdata, // answer
  input wire logic rvalid // answer valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [11:0] cnt_r; // cycles since trigger
  logic hi_r; // last read hit offset 5
  logic [8:0] gap_r; // cycles since channel write, saturating
  wire hit = addr[9:4] == BASE;
  wire trig = wr && hit && addr[3:0] == OFS_TRIG;
  // trigger age and read history
  always_ff @(posedge clk) begin
    if (!rstn) cnt_r <= 12'hfff;
    else if (trig) cnt_r <= 12'h000;
    else if (cnt_r != 12'hfff) cnt_r <= cnt_r + 12'h001;
    if (!rstn) hi_r <= 1'b0;
    else if (rd) hi_r <= hit && addr[3:0] == OFS_RES_HI;
  end
  // settle gap after channel select
  always_ff @(posedge clk) begin
    if (!rstn) gap_r <= 9'h1ff;
    else if (wr && hit && addr[3:0] == OFS_CHAN) gap_r <= 9'h000;
    else if (gap_r != 9'h1ff) gap_r <= gap_r + 9'h001;
  end
  sequence s_chan;
    wr && hit && addr[3:0] == OFS_CHAN;
  endsequence
  sequence s_quiet;
    !wr [*8];
  endsequence
  a_read_answer: assert property (rd && hit |=> rvalid)
    else $error("read in window not answered");
  a_out_window: assert property (rd && !hit |=> !rvalid)
    else $error("read outside window answered");
  a_no_stray: assert property (!rd |=> !rvalid)
    else $error("answer without read");
  a_idle_zero: assert property (!rvalid |-> rdata == 8'h00)
    else $error("read data not zero when idle");
  a_hi_spare: assert property (rvalid && hi_r |-> rdata[7:5] == 3'h0)
    else $error("spare high bits set");
  a_busy_on: assert property (rvalid && hi_r && cnt_r inside {[1:1250]} |-> rdata[4])
    else $error("flag low during conversion");
  a_busy_off: assert property (rvalid && hi_r && cnt_r >= 12'd1251 |-> !rdata[4])
    else $error("flag high after conversion");
  a_poll_wait: assert property (rd && hit |-> cnt_r >= 12'd1000)
    else $error("poll too soon after trigger");
  a_settle_gap: assert property (s_chan |=> s_quiet)
    else $error("command too soon after channel");
  a_settle_time: assert property (trig |-> gap_r >= 9'(SETTLE_CYC))
    else $error("trigger inside settle time");
  a_chan_field: assert property (s_chan |-> wdata[7:5] == 3'h0)
    else $error("channel write with spare bits set");
  a_hi_first: assert property (rd && hit && addr[3:0] == OFS_RES_LO |-> hi_r)
    else $error("low byte read before high byte");
endmodule // paic_assertions

// *** test/tb_polled_adc_card_io_port.sv ***
// testbench: host and card ends joined over the i/o bus
`timescale 1ns/1ps
module tb_polled_adc_card_io_port import paic_pkg::*; ;
  logic clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, rd_d = 0, irq, conv_start;
  logic [2:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0, reg_rdata;
  logic [5:0] sw = 6'h22;
  logic [11:0] sample = '0;
  logic [1:0] gain_code;
  logic [4:0] channel_code;
  logic [15:0] exp_q[$];
  int miscompares = 0, total_checks = 0, starts = 0, c;
  always #10 clk = ~clk;
  paic_if paic_if_i ();
  paic_card paic_card_i (.clk(clk), .rstn(rstn), .bus(paic_if_i), .base_address_switch(sw),
    .adc_sample(sample), .gain_code(gain_code), .channel_code(channel_code),
    .conv_start(conv_start));
  paic_host paic_host_i (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .bus(paic_if_i));
  paic_assertions #(.BASE(6'h22)) paic_assertions_i (.clk(clk), .rstn(rstn),
    .addr(paic_if_i.addr), .wdata(paic_if_i.wdata), .wr(paic_if_i.wr), .rd(paic_if_i.rd),
    .rdata(paic_if_i.rdata), .rvalid(paic_if_i.rvalid));
  task automatic test_done();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // register port cycles
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (irq !== 1'b1) begin
      miscompares++;
      test_done();
    end
  endtask
  // read data watcher, conversion start counter
  always @(posedge clk) begin
    if (rd_d) chk("reg_rdata", reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
    if (conv_start === 1'b1) starts++;
  end
  // main sequence
  initial begin
    c = $urandom(32'h96f59831);
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(CR_BASE, 16'h0022);
    chk("gain_code", 16'(gain_code), 16'h0000);
    wr(CR_IRQ_MASK, 16'h0002);
    for (int k = 0; k < 4; k++) begin
      c = (k == 3) ? 31 : int'($urandom % 32);
      sample <= 12'($urandom);
      wr(CR_GAIN, 16'(k));
      wr(CR_CHAN, 16'(c));
      wr(CR_CTRL, 16'h0001);
      rd(CR_CTRL, 16'h0001);
      wait_irq();
      rd(CR_CTRL, 16'h0000);
      rd(CR_GAIN, 16'(k));
      rd(CR_CHAN, 16'(c));
      chk("gain_code", 16'(gain_code), 16'(k));
      chk("channel_code", 16'(channel_code), 16'(c));
      chk("starts", 16'(starts), 16'(k + 1));
      rd(CR_RESULT, {4'h0, sample});
      wr(CR_IRQ_ST, 16'h0003);
      rd(CR_IRQ_ST, 16'h0000);
    end
    // masked completion, then unmask and clear
    wr(CR_IRQ_MASK, 16'h0000);
    wr(CR_CTRL, 16'h0001);
    repeat (3000) @(posedge clk);
    chk("irq", 16'(irq), 16'h0000);
    chk("starts", 16'(starts), 16'h0005);
    rd(CR_IRQ_ST, 16'h0003);
    wr(CR_IRQ_MASK, 16'h0002);
    repeat (2) @(posedge clk);
    chk("irq", 16'(irq), 16'h0001);
    wr(CR_IRQ_ST, 16'h0003);
    repeat (2) @(posedge clk);
    chk("irq", 16'(irq), 16'h0000);
    // host base moved off the switch: card must ignore it
    wr(CR_BASE, 16'h0023);
    wr(CR_GAIN, 16'h0001);
    wr(CR_CHAN, 16'h0005);
    wr(CR_CTRL, 16'h0001);
    repeat (300) @(posedge clk);
    chk("gain_code", 16'(gain_code), 16'h0003);
    chk("channel_code", 16'(channel_code), 16'h001f);
    chk("starts", 16'(starts), 16'h0005);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(CR_BASE, 16'h0022);
    repeat (3) @(posedge clk);
    test_done();
  end
endmodule // tb_polled_adc_card_io_port
